// File: rtl/prog_word_array.sv
/*
 * Program memory array of 16-bit words with registered read data.
 * Assumes reads and writes arrive through prog_mem_if on clock_in.
 */
`timescale 1ns/1ps
`default_nettype none

module prog_word_array #(
    parameter int ADDR_W = 21
) (
    input  wire logic     clock_in,
    prog_mem_if.array     mem
);
    logic [15:0] word_reg [0:(1<<ADDR_W)-1];
    logic [15:0] rdata_reg;

    always_ff @(posedge clock_in)
    begin
        if (mem.wr_en)
        begin
            word_reg[mem.addr] <= mem.wdata;
        end
        if (mem.rd_en)
        begin
            rdata_reg <= word_reg[mem.addr];
        end
    end

    assign mem.rdata = rdata_reg;
endmodule

`default_nettype wire

// File: rtl/table_access_unit.sv
/*
 * Table read and write unit: byte pointer, transfer latch, holding register,
 * long-write sequencing and the reset control register.
 * Assumes the core issues one table operation at a time and stalls on busy.
 */
// Functional notes
// - Three pointer registers form a 22-bit pointer; top bit selects config space.
// - Automatic pointer updates touch only the low 21 bits.
// - Pointer modes: keep, post-increment, post-decrement, pre-increment.
// - A table read loads the latch with the one addressed byte.
// - The 8-bit transfer latch is a register in the register space.
// - Memory words are 16 bits; transfers are single bytes at any address.
// - Internal memory is programmed two bytes at a time, by paired writes.
// - An even-address write copies the latch into the holding register only.
// - The holding register has no register address.
// - An odd-address write programs latch as high byte, holding as low byte.
// - A long write halts execution while data is applied to memory.
// - The halt keeps clocks and peripherals running; it is not sleep.
// - Long write needs programming voltage, enable bit and odd address together.
// - With the enable bit clear a write stays short; memory unchanged.
// - The long-write enable clears only on power-on or master-clear reset.
// - The enable bit has no effect on writes to external memory.
// - A long write ends on a reset or an interrupt, then operation resumes.
// - Reset control: priority bit 7, enable bit 6, bit 5 zero, flags below.
// - Power-on reset clears the power-on flag; software sets it again.
// - Only an enabled source whose flag sets ends a long write; flag kept.
`timescale 1ns/1ps
`default_nettype none
`include "table_access_map.svh"

module table_access_unit #(
    parameter int WORD_AW = 20,
    parameter int IRQ_N   = 8
) (
    input  wire logic                      clock_in,
    input  wire logic                      reset_n_in,
    input  wire logic [11:0]               sfr_addr_in,
    input  wire logic                      sfr_wr_in,
    input  wire logic [7:0]                sfr_wdata_in,
    output logic [7:0]                     sfr_rdata_out,
    input  wire logic                      op_valid_in,
    input  wire logic                      op_write_in,
    input  wire table_access_pkg::ptr_mode_e op_mode_in,
    output logic                           busy_out,
    output logic                           done_out,
    output logic                           halt_out,
    input  wire logic                      vpp_pin_in,
    input  wire logic [IRQ_N-1:0]          irq_flag_in,
    input  wire logic [IRQ_N-1:0]          irq_enable_in,
    input  wire logic                      ext_mem_sel_in,
    output logic                           ext_wr_out,
    output logic [21:0]                    ext_addr_out,
    output logic [7:0]                     ext_data_out,
    input  wire logic                      master_clear_pin_reset_in,
    input  wire logic                      reset_instr_in,
    input  wire logic                      wdt_timeout_in,
    input  wire logic                      sleep_in,
    input  wire logic                      watchdog_clear_op_in,
    input  wire logic                      brownout_in,
    output logic                           irq_priority_enable_out
);
    import table_access_pkg::*;
    localparam int MEM_AW = WORD_AW + 1;
    // Pointer step on the low 21 bits only
    function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic dec);
        ptr_step = {p[`PTR_SPACE_BIT], dec ? p[20:0] - 21'h1 : p[20:0] + 21'h1};
    endfunction
    // Byte address to word address, space bit kept on top
    function automatic logic [MEM_AW-1:0] word_addr(input logic [21:0] p);
        word_addr = {p[`PTR_SPACE_BIT], p[WORD_AW:1]};
    endfunction
    seq_state_e           state_reg;
    seq_state_e           state_next;
    logic [21:0]          ptr_reg;
    logic [21:0]          ptr_next;
    logic [21:0]          acc_reg;
    logic [7:0]           latch_reg;
    logic [7:0]           latch_next;
    logic [7:0]           hold_reg;
    logic [7:0]           reset_control_flags_reg;
    logic [7:0]           reset_control_flags_next;
    logic                 vpp_s1_reg;
    logic                 vpp_s2_reg;
    logic                 vpp_s3_reg;
    logic                 vpp_ok_reg;
    logic                 done_reg;
    logic                 halt_reg;
    logic                 ext_wr_reg;
    logic [21:0]          ext_addr_reg;
    logic [7:0]           ext_data_reg;
    logic [7:0]           rdata_reg;
    logic [7:0]           rdata_next;
    logic                 busy_reg;
    prog_mem_if #(.ADDR_W(MEM_AW)) mem_bus ();
    prog_word_array #(.ADDR_W(MEM_AW)) u_array (
        .clock_in (clock_in),
        .mem      (mem_bus.array)
    );
    // Operation decode
    wire         idle        = (state_reg == ST_IDLE);
    wire         op_accept   = op_valid_in && idle;
    wire         rd_accept   = op_accept && !op_write_in;
    wire         wr_accept   = op_accept && op_write_in;
    wire [21:0]  acc_ptr     = (op_mode_in == PTR_PRE_INC) ? ptr_step(ptr_reg, 1'b0)
                                                           : ptr_reg;
    wire [21:0]  post_ptr    = (op_mode_in == PTR_POST_INC) ? ptr_step(acc_ptr, 1'b0) :
                               (op_mode_in == PTR_POST_DEC) ? ptr_step(acc_ptr, 1'b1) :
                               acc_ptr;
    wire         long_write_enable        = reset_control_flags_reg[`RC_LONG_WRITE_BIT];
    wire         wr_ext      = wr_accept && ext_mem_sel_in;
    wire         wr_int      = wr_accept && !ext_mem_sel_in;
    wire         wr_odd      = acc_ptr[0];
    wire         long_start  = wr_int && wr_odd && long_write_enable && vpp_ok_reg;
    wire         short_write = wr_int && !long_start;
    wire         terminate   = |(irq_flag_in & irq_enable_in);
    wire         long_end    = (state_reg == ST_LONG_WR) && terminate;
    wire         rd_done     = (state_reg == ST_RD_WAIT);
    wire [7:0]   rd_byte     = acc_reg[0] ? mem_bus.rdata[15:8]
                                          : mem_bus.rdata[7:0];
    // Register space decode; holding register has no address
    wire sel_reset_control_flags  = (sfr_addr_in == `RESET_CONTROL_ADDR);
    wire sel_latch = (sfr_addr_in == `TRANSFER_LATCH_ADDR);
    wire sel_ptrl  = (sfr_addr_in == `POINTER_LOW_ADDR);
    wire sel_ptrh  = (sfr_addr_in == `POINTER_HIGH_ADDR);
    wire sel_ptru  = (sfr_addr_in == `POINTER_UPPER_ADDR);
    wire wr_reset_control_flags   = sfr_wr_in && sel_reset_control_flags;
    wire wr_latch  = sfr_wr_in && sel_latch;
    // Memory port
    assign mem_bus.rd_en = rd_accept;
    assign mem_bus.wr_en = long_start;
    assign mem_bus.addr  = word_addr(acc_ptr);
    assign mem_bus.wdata = {latch_reg, hold_reg};
    // Sequencer
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (rd_accept)
                begin
                    state_next = ST_RD_WAIT;
                end
                else if (long_start)
                begin
                    state_next = ST_LONG_WR;
                end
            end
            ST_RD_WAIT:
            begin
                state_next = ST_IDLE;
            end
            ST_LONG_WR:
            begin
                if (terminate)
                begin
                    state_next = ST_IDLE;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end
    // Pointer: table operation wins over a register write
    always_comb
    begin
        ptr_next = ptr_reg;
        if (sfr_wr_in && sel_ptrl)
        begin
            ptr_next[7:0] = sfr_wdata_in;
        end
        if (sfr_wr_in && sel_ptrh)
        begin
            ptr_next[15:8] = sfr_wdata_in;
        end
        if (sfr_wr_in && sel_ptru)
        begin
            ptr_next[21:16] = sfr_wdata_in[5:0];
        end
        if (op_accept)
        begin
            ptr_next = post_ptr;
        end
    end
    // Transfer latch: a completing read wins over a register write
    assign latch_next = rd_done  ? rd_byte :
                        wr_latch ? sfr_wdata_in :
                        latch_reg;
    // Reset control: hardware events win over software writes
    always_comb
    begin
        reset_control_flags_next = reset_control_flags_reg;
        if (wr_reset_control_flags)
        begin
            reset_control_flags_next = sfr_wdata_in & `RC_WRITE_MASK;
            reset_control_flags_next[`RC_LONG_WRITE_BIT] = long_write_enable | sfr_wdata_in[`RC_LONG_WRITE_BIT];
        end
        if (master_clear_pin_reset_in)
        begin
            reset_control_flags_next[`RC_LONG_WRITE_BIT] = 1'b0;
        end
        if (reset_instr_in)
        begin
            reset_control_flags_next[`RC_RESET_INSTR_BIT] = 1'b0;
        end
        if (wdt_timeout_in)
        begin
            reset_control_flags_next[`RC_TIMEOUT_BIT] = 1'b0;
        end
        if (sleep_in)
        begin
            reset_control_flags_next[`RC_TIMEOUT_BIT]    = 1'b1;
            reset_control_flags_next[`RC_POWER_DOWN_BIT] = 1'b0;
        end
        if (watchdog_clear_op_in)
        begin
            reset_control_flags_next[`RC_TIMEOUT_BIT]    = 1'b1;
            reset_control_flags_next[`RC_POWER_DOWN_BIT] = 1'b1;
        end
        if (brownout_in)
        begin
            reset_control_flags_next[`RC_BROWNOUT_BIT] = 1'b0;
        end
    end

    // Read data select, registered below
    assign rdata_next = sel_reset_control_flags  ? reset_control_flags_reg :
                        sel_latch ? latch_reg :
                        sel_ptrl  ? ptr_reg[7:0] :
                        sel_ptrh  ? ptr_reg[15:8] :
                        sel_ptru  ? {2'b00, ptr_reg[21:16]} :
                        8'h00;
    // Programming voltage detect: three flops, change when last two agree
    always_ff @(posedge clock_in)
    begin
        vpp_s1_reg <= vpp_pin_in;
        vpp_s2_reg <= vpp_s1_reg;
        vpp_s3_reg <= vpp_s2_reg;
        if (!reset_n_in)
        begin
            vpp_ok_reg <= 1'b0;
        end
        else if (vpp_s2_reg == vpp_s3_reg)
        begin
            vpp_ok_reg <= vpp_s3_reg;
        end
    end
    // Control state
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            state_reg <= ST_IDLE;
            ptr_reg   <= 22'({`PTR_UPPER_RESET, 16'h0000});
            latch_reg <= `LATCH_RESET;
            reset_control_flags_reg  <= `RC_RESET_VALUE;
            done_reg  <= 1'b0;
            halt_reg  <= 1'b0;
            busy_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            ptr_reg   <= ptr_next;
            latch_reg <= latch_next;
            reset_control_flags_reg  <= reset_control_flags_next;
            done_reg  <= rd_done || long_end || wr_ext || short_write;
            halt_reg  <= long_start || (halt_reg && !terminate);
            busy_reg  <= (state_next != ST_IDLE);
        end
    end
    // Access address and holding register
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            acc_reg  <= 22'h000000;
            hold_reg <= 8'h00;
        end
        else
        begin
            if (op_accept)
            begin
                acc_reg <= acc_ptr;
            end
            if (short_write && !wr_odd)
            begin
                hold_reg <= latch_reg;
            end
        end
    end

    // External write strobe and read port
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            ext_wr_reg   <= 1'b0;
            ext_addr_reg <= 22'h000000;
            ext_data_reg <= 8'h00;
            rdata_reg    <= 8'h00;
        end
        else
        begin
            ext_wr_reg <= wr_ext;
            rdata_reg  <= rdata_next;
            if (wr_ext)
            begin
                ext_addr_reg <= acc_ptr;
                ext_data_reg <= latch_reg;
            end
        end
    end

    assign sfr_rdata_out           = rdata_reg;
    assign busy_out                = busy_reg;
    assign done_out                = done_reg;
    assign halt_out                = halt_reg;
    assign ext_wr_out              = ext_wr_reg;
    assign ext_addr_out            = ext_addr_reg;
    assign ext_data_out            = ext_data_reg;
    assign irq_priority_enable_out = reset_control_flags_reg[`RC_PRIORITY_BIT];
endmodule

`default_nettype wire

// File: shared/prog_mem_if.sv
/*
 * Word port between the table sequencer and the program word array.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface prog_mem_if #(parameter int ADDR_W = 21);
    logic              rd_en;
    logic              wr_en;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
    logic [15:0]       rdata;

    modport ctrl  (output rd_en, output wr_en, output addr, output wdata, input rdata);
    modport array (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

// File: shared/table_access_map.svh
/*
 * Offsets, field positions, reset values and codes of the table access unit.
 * Assumes a 12-bit special function register address space.
 */
`ifndef TABLE_ACCESS_MAP_SVH
`define TABLE_ACCESS_MAP_SVH

// Register addresses
`define RESET_CONTROL_ADDR      12'hFD0
`define TRANSFER_LATCH_ADDR     12'hFF5
`define POINTER_LOW_ADDR        12'hFF6
`define POINTER_HIGH_ADDR       12'hFF7
`define POINTER_UPPER_ADDR      12'hFF8

// Reset control fields
`define RC_PRIORITY_BIT         7
`define RC_LONG_WRITE_BIT       6
`define RC_RESET_INSTR_BIT      4
`define RC_TIMEOUT_BIT          3
`define RC_POWER_DOWN_BIT       2
`define RC_POWER_ON_BIT         1
`define RC_BROWNOUT_BIT         0
`define RC_WRITE_MASK           8'hDF
`define RC_RESET_VALUE          8'h1C

// Pointer layout
`define PTR_WIDTH               22
`define PTR_SPACE_BIT           21
`define PTR_UPPER_RESET         8'h00
`define LATCH_RESET             8'h00

`endif

// File: shared/table_access_pkg.sv
/*
 * Types of the table access unit: pointer update modes and sequencer states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package table_access_pkg;

    typedef enum logic [1:0] {
        PTR_KEEP     = 2'b00,
        PTR_POST_INC = 2'b01,
        PTR_POST_DEC = 2'b10,
        PTR_PRE_INC  = 2'b11
    } ptr_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_RD_WAIT = 2'b01,
        ST_LONG_WR = 2'b10
    } seq_state_e;

endpackage

// File: verif/ext_prog_mem_model.sv
/* External program memory model: keeps the last byte written.
   Assumes strobe, address and data from the unit on one clock. */
`timescale 1ns/1ps
`default_nettype none

module ext_prog_mem_model (
    input  wire logic        clock_in,
    input  wire logic        wr_in,
    input  wire logic [21:0] addr_in,
    input  wire logic [7:0]  data_in,
    output logic [21:0]      addr_out,
    output logic [7:0]       data_out
);
    always_ff @(posedge clock_in)
    begin
        if (wr_in)
        begin
            addr_out <= addr_in;
            data_out <= data_in;
        end
    end
endmodule

`default_nettype wire

// File: verif/table_access_unit_asserts.sv
/* Port checks of the table access unit.
   Assumes it is bound to table_access_unit. */
`timescale 1ns/1ps
`default_nettype none
`include "table_access_map.svh"

module table_access_unit_asserts #(
    parameter int IRQ_N = 8
) (
    input wire logic             clock_in,
    input wire logic             reset_n_in,
    input wire logic [11:0]      sfr_addr_in,
    input wire logic             sfr_wr_in,
    input wire logic [7:0]       sfr_wdata_in,
    input wire logic [7:0]       sfr_rdata_out,
    input wire logic             op_valid_in,
    input wire logic             op_write_in,
    input wire logic             busy_out,
    input wire logic             done_out,
    input wire logic             halt_out,
    input wire logic [IRQ_N-1:0] irq_flag_in,
    input wire logic [IRQ_N-1:0] irq_enable_in,
    input wire logic             ext_mem_sel_in,
    input wire logic             ext_wr_out,
    input wire logic             irq_priority_enable_out
);
    logic irq_hit;
    logic wr_take;
    assign irq_hit = |(irq_flag_in & irq_enable_in);
    assign wr_take = op_valid_in && op_write_in && !busy_out;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);

    a_read_two_cycles: assert property (
        op_valid_in && !busy_out && !op_write_in |=> busy_out ##1 (done_out && !busy_out))
        else $error("read answer late");
    a_halt_holds: assert property (halt_out && !irq_hit |=> halt_out)
        else $error("long write ended early");
    a_halt_ends_irq: assert property (
        halt_out && irq_hit |-> ##[1:2] (!halt_out && done_out))
        else $error("long write not ended");
    a_halt_busy: assert property (halt_out |-> busy_out)
        else $error("halt without busy");
    a_long_cause: assert property (
        $rose(halt_out) |-> $past(wr_take) && !$past(ext_mem_sel_in))
        else $error("halt without write");
    a_ext_strobe: assert property (
        wr_take && ext_mem_sel_in |-> ##[1:2] (ext_wr_out && !halt_out))
        else $error("external write missing");
    a_bit5_zero: assert property (
        sfr_addr_in == `RESET_CONTROL_ADDR |=> !sfr_rdata_out[5])
        else $error("reserved bit set");
    a_upper_masked: assert property (
        sfr_addr_in == `POINTER_UPPER_ADDR |=> sfr_rdata_out[7:6] == 2'b00)
        else $error("upper bits set");
    a_priority_write: assert property (
        sfr_wr_in && sfr_addr_in == `RESET_CONTROL_ADDR
        |=> irq_priority_enable_out == $past(sfr_wdata_in[7]))
        else $error("priority bit wrong");

    c_long: cover property ($rose(halt_out));
    c_ext: cover property (ext_wr_out);
    c_done: cover property (done_out && !halt_out);
endmodule

`default_nettype wire

// File: verif/table_access_unit_test.sv
/* Self-checking bench for the table access unit.
   Assumes the checker and the external memory model compile first. */
`timescale 1ns/1ps
`default_nettype none
`include "table_access_map.svh"

module table_access_unit_test;
    import table_access_pkg::*;

    logic        clock_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [11:0] sfr_addr_in = 12'h000;
    logic        sfr_wr_in = 1'b0;
    logic [7:0]  sfr_wdata_in = 8'h00;
    logic        op_valid_in = 1'b0;
    logic        op_write_in = 1'b0;
    ptr_mode_e   op_mode_in = PTR_KEEP;
    logic        vpp_pin_in = 1'b0;
    logic [7:0]  irq_flag_in = 8'h00;
    logic [7:0]  irq_enable_in = 8'h00;
    logic        ext_mem_sel_in = 1'b0;
    logic [5:0]  ev = 6'h00;
    wire logic   wdt_timeout_in = ev[0];
    wire logic   sleep_in = ev[1];
    wire logic   watchdog_clear_op_in = ev[2];
    wire logic   reset_instr_in = ev[3];
    wire logic   brownout_in = ev[4];
    wire logic   master_clear_pin_reset_in = ev[5];
    logic [7:0]  sfr_rdata_out;
    logic        busy_out;
    logic        done_out;
    logic        halt_out;
    logic        ext_wr_out;
    logic [21:0] ext_addr_out;
    logic [7:0]  ext_data_out;
    logic        irq_priority_enable_out;
    logic [21:0] ext_addr_seen;
    logic [7:0]  ext_data_seen;
    logic [7:0]  ev_exp [0:5] = '{8'h57, 8'h5B, 8'h5F, 8'h4F, 8'h4E, 8'h0E};
    int          failures = 0;
    int          n_compared = 0;

    always #25 clock_in = ~clock_in;

    table_access_unit #(.WORD_AW(6), .IRQ_N(8)) i_dut (.*);

    ext_prog_mem_model i_ext (
        .clock_in (clock_in),
        .wr_in    (ext_wr_out),
        .addr_in  (ext_addr_out),
        .data_in  (ext_data_out),
        .addr_out (ext_addr_seen),
        .data_out (ext_data_seen)
    );

    task automatic conclude;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock_in);
        sfr_wr_in <= 1'b1;
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        @(posedge clock_in);
        sfr_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        sfr_addr_in <= a;
        @(posedge clock_in);
        #1;
        check($sformatf("reg_%h", a), sfr_rdata_out, exp);
    endtask

    task automatic set_ptr(input logic [21:0] p);
        wr(`POINTER_UPPER_ADDR, {2'b00, p[21:16]});
        wr(`POINTER_HIGH_ADDR, p[15:8]);
        wr(`POINTER_LOW_ADDR, p[7:0]);
    endtask

    task automatic wait_done;
        int k;
        #1;
        for (k = 0; k < 60 && done_out !== 1'b1; k++)
        begin
            @(posedge clock_in);
            #1;
        end
        if (done_out !== 1'b1)
        begin
            failures++;
            conclude();
        end
    endtask

    task automatic op(input logic w, input ptr_mode_e m, input logic wt);
        @(posedge clock_in);
        op_valid_in <= 1'b1;
        op_write_in <= w;
        op_mode_in <= m;
        @(posedge clock_in);
        op_valid_in <= 1'b0;
        if (wt)
        begin
            wait_done();
            check("halt_idle", {7'h00, halt_out}, 8'h00);
        end
    endtask

    initial
    begin
        repeat (3) @(posedge clock_in);
        reset_n_in <= 1'b1;
        vpp_pin_in <= 1'b1;
        irq_enable_in <= 8'h04;
        rd(`RESET_CONTROL_ADDR, 8'h1C);
        rd(12'hFA0, 8'h00);
        wr(`TRANSFER_LATCH_ADDR, 8'h5A);
        rd(`TRANSFER_LATCH_ADDR, 8'h5A);
        set_ptr(22'h3FFFFF);
        rd(`POINTER_UPPER_ADDR, 8'h3F);
        op(1'b0, PTR_POST_INC, 1'b1);
        rd(`POINTER_UPPER_ADDR, 8'h20);
        rd(`POINTER_LOW_ADDR, 8'h00);
        op(1'b0, PTR_POST_DEC, 1'b1);
        rd(`POINTER_UPPER_ADDR, 8'h3F);
        set_ptr(22'h000005);
        op(1'b1, PTR_KEEP, 1'b1);
        wr(`RESET_CONTROL_ADDR, 8'hDF);
        rd(`RESET_CONTROL_ADDR, 8'hDF);
        check("priority", {7'h00, irq_priority_enable_out}, 8'h01);
        wr(`RESET_CONTROL_ADDR, 8'h00);
        rd(`RESET_CONTROL_ADDR, 8'h40);
        wr(`RESET_CONTROL_ADDR, 8'h1F);
        set_ptr(22'h000002);
        wr(`TRANSFER_LATCH_ADDR, 8'hA5);
        op(1'b1, PTR_POST_INC, 1'b1);
        rd(`POINTER_LOW_ADDR, 8'h03);
        wr(`TRANSFER_LATCH_ADDR, 8'h3C);
        op(1'b1, PTR_KEEP, 1'b0);
        repeat (4) @(posedge clock_in);
        irq_flag_in <= 8'h01;
        repeat (4) @(posedge clock_in);
        #1;
        check("halt", {7'h00, halt_out}, 8'h01);
        check("busy", {7'h00, busy_out}, 8'h01);
        rd(`POINTER_LOW_ADDR, 8'h03);
        @(posedge clock_in);
        irq_flag_in <= 8'h05;
        wait_done();
        @(posedge clock_in);
        irq_flag_in <= 8'h00;
        set_ptr(22'h000002);
        op(1'b0, PTR_POST_INC, 1'b1);
        rd(`TRANSFER_LATCH_ADDR, 8'hA5);
        op(1'b0, PTR_POST_DEC, 1'b1);
        rd(`TRANSFER_LATCH_ADDR, 8'h3C);
        rd(`POINTER_LOW_ADDR, 8'h02);
        op(1'b0, PTR_PRE_INC, 1'b1);
        rd(`TRANSFER_LATCH_ADDR, 8'h3C);
        rd(`POINTER_LOW_ADDR, 8'h03);
        @(posedge clock_in);
        ext_mem_sel_in <= 1'b1;
        set_ptr(22'h000007);
        wr(`TRANSFER_LATCH_ADDR, 8'h77);
        op(1'b1, PTR_KEEP, 1'b1);
        repeat (2) @(posedge clock_in);
        ext_mem_sel_in <= 1'b0;
        #1;
        check("ext_addr", ext_addr_seen[7:0], 8'h07);
        check("ext_addr_hi", {2'b00, ext_addr_seen[21:16]}, 8'h00);
        check("ext_data", ext_data_seen, 8'h77);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clock_in);
            ev <= 6'(1 << i);
            @(posedge clock_in);
            ev <= 6'h00;
            rd(`RESET_CONTROL_ADDR, ev_exp[i]);
        end
        @(posedge clock_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        reset_n_in <= 1'b1;
        rd(`RESET_CONTROL_ADDR, 8'h1C);
        conclude();
    end
endmodule

bind table_access_unit table_access_unit_asserts #(.IRQ_N(IRQ_N)) i_chk (.*);

`default_nettype wire
